// *** core/tsq_pkg.sv ***
package tsq_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the 32-bit bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_C1LIM = 6'h00;
  localparam logic [5:0] OFS_HOLD = 6'h04;
  localparam logic [5:0] OFS_ADJ = 6'h08;
  localparam logic [5:0] OFS_LIT = 6'h0C;
  localparam logic [5:0] OFS_QPTR = 6'h10;
  localparam logic [5:0] OFS_CTRL = 6'h14;
  localparam logic [5:0] OFS_QUEUE = 6'h20;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_C1LIM = 16'h0000;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic [15:0] RST_ADJ = 16'h0000;
  localparam logic [15:0] RST_LIT = 16'h0000;
  localparam logic [4:0] RST_QPTR = 5'h00;
  localparam int QPTR_W = 5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int QUEUE_WORDS = 8;
  localparam int STEP_CMD_LSB = 4;
  localparam int STEP_COPY_BIT = 3;

  // ----------------------------------------------------------------
  // Step command and option codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_CTRL = 4'h0;
  localparam logic [3:0] CMD_ADDCOPY = 4'h1;
  localparam logic [2:0] CMD_JMP = 3'h5;
  localparam logic [2:0] CMD_JMPC0 = 3'h6;
  localparam logic [2:0] CMD_JMPC1 = 3'h7;
  localparam logic [3:0] OPT_C1_TO_ADC = 4'hD;
  localparam logic [3:0] OPT_LIT_TO_ADC = 4'hE;
  localparam logic [2:0] TGT_C1LIM = 3'h1;
  localparam logic [2:0] TGT_LIT = 3'h5;

  typedef enum logic [2:0] {
    TSQ_RD_IDLE = 3'b001,
    TSQ_RD_FETCH = 3'b010,
    TSQ_RD_DONE = 3'b100
  } tsq_rd_e;

endpackage

// *** core/tsq_step_mem.sv ***
module tsq_step_mem
  import tsq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [1:0] wr_be_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [2:0] rd_idx_i,
  output logic [15:0] rd_word_o,
  input wire logic [3:0] slot_i,
  output logic [7:0] slot_byte_o
);

  typedef struct packed {
    logic [QUEUE_WORDS-1:0][15:0] mem;
    logic [15:0] word;
    logic [7:0] slot;
  } tsq_mem_s;

  tsq_mem_s st;
  tsq_mem_s next_st;

  // Odd slot in the upper byte, even slot in the lower byte.
  always_comb begin
    next_st = st;
    for (int b = 0; b < 2; b++) begin
      if (wr_en_i && wr_be_i[b]) begin
        next_st.mem[wr_idx_i][b*8 +: 8] = wr_data_i[b*8 +: 8];
      end
    end
    next_st.word = st.mem[rd_idx_i];
    next_st.slot = slot_i[0] ? st.mem[slot_i[3:1]][15:8] : st.mem[slot_i[3:1]][7:0];
  end

  // The queue contents are never touched by reset.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st.word <= 16'h0000;
      st.slot <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign rd_word_o = st.word;
  assign slot_byte_o = st.slot;

endmodule

// *** core/tsq_step_decode.sv ***
module tsq_step_decode
  import tsq_pkg::*;
(
  input wire logic [7:0] step_byte_i,
  output logic [3:0] cmd_o,
  output logic [3:0] option_o,
  output logic [4:0] target_o,
  output logic is_ctrl_o,
  output logic is_addcopy_o,
  output logic is_copy_o,
  output logic is_jmp_o,
  output logic is_jmpc0_o,
  output logic is_jmpc1_o
);

  // Command code in the upper nibble, option in the lower nibble.
  assign cmd_o = step_byte_i[7:STEP_CMD_LSB];
  assign option_o = step_byte_i[STEP_CMD_LSB-1:0];
  assign target_o = step_byte_i[STEP_CMD_LSB:0];
  assign is_ctrl_o = (cmd_o == CMD_CTRL);
  assign is_addcopy_o = (cmd_o == CMD_ADDCOPY);
  assign is_copy_o = is_addcopy_o & option_o[STEP_COPY_BIT];
  assign is_jmp_o = (cmd_o[3:1] == CMD_JMP);
  assign is_jmpc0_o = (cmd_o[3:1] == CMD_JMPC0);
  assign is_jmpc1_o = (cmd_o[3:1] == CMD_JMPC1);

endmodule

// *** core/tsq_queue_regs.sv ***
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
module tsq_queue_regs
  import tsq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic step_exec_i,
  input wire logic c0_at_limit_i,
  output logic [7:0] step_byte_o,
  output logic step_valid_o,
  output logic [QPTR_W-1:0] queue_pointer_o,
  output logic [15:0] counter_one_limit_o,
  output logic [15:0] hold_operand_o,
  output logic [15:0] adjust_operand_o,
  output logic [15:0] literal_zero_value_o,
  output logic [15:0] loop_counter_one_o,
  output logic [15:0] adc_channel_select_o,
  output logic adc_select_load_o,
  output logic sequencer_enable_o,
  output logic sequencer_run_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] c1lim;
    logic [15:0] hold;
    logic [15:0] adj;
    logic [15:0] lit;
    logic [QPTR_W-1:0] qptr;
    logic [QPTR_W-1:0] fptr;
    logic en;
    logic run;
    logic [15:0] cnt1;
    logic [15:0] adc;
    logic adc_ld;
    logic [31:0] rdata;
    tsq_rd_e rd;
  } tsq_regs_s;

  tsq_regs_s st;
  tsq_regs_s next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam int H_C1LIM = 0;
  localparam int H_HOLD = 1;
  localparam int H_ADJ = 2;
  localparam int H_LIT = 3;
  localparam int H_QPTR = 4;
  localparam int H_CTRL = 5;
  localparam int H_QUEUE = 6;

  function automatic logic [6:0] reg_hit(input logic [ADDR_W-1:0] a);
    logic [6:0] h;
    h = 7'h00;
    h[H_C1LIM] = (a == OFS_C1LIM);
    h[H_HOLD] = (a == OFS_HOLD);
    h[H_ADJ] = (a == OFS_ADJ);
    h[H_LIT] = (a == OFS_LIT);
    h[H_QPTR] = (a == OFS_QPTR);
    h[H_CTRL] = (a == OFS_CTRL);
    h[H_QUEUE] = (a[5] == OFS_QUEUE[5]) && (a[1:0] == 2'b00);
    return h;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Step queue and step decode
  // ----------------------------------------------------------------
  logic [6:0] hit;
  logic locked;
  logic sw_write;
  logic [15:0] mem_word;
  logic [7:0] slot_byte;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic [4:0] target;
  logic is_ctrl;
  logic is_addcopy;
  logic is_copy;
  logic is_jmp;
  logic is_jmpc0;
  logic is_jmpc1;
  logic exec_go;
  logic [15:0] operand;

  assign hit = reg_hit(avs_address_i);
  assign locked = st.en & st.run;
  // Software writes reach these registers only while the sequencer is stopped.
  assign sw_write = avs_write_i & ~locked;

  tsq_step_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(sw_write & hit[H_QUEUE]),
    .wr_idx_i(avs_address_i[4:2]),
    .wr_be_i(avs_byteenable_i[1:0]),
    .wr_data_i(avs_writedata_i[15:0]),
    .rd_idx_i(avs_address_i[4:2]),
    .rd_word_o(mem_word),
    .slot_i(st.qptr[3:0]),
    .slot_byte_o(slot_byte)
  );

  tsq_step_decode u_dec (
    .step_byte_i(slot_byte),
    .cmd_o(cmd),
    .option_o(opt),
    .target_o(target),
    .is_ctrl_o(is_ctrl),
    .is_addcopy_o(is_addcopy),
    .is_copy_o(is_copy),
    .is_jmp_o(is_jmp),
    .is_jmpc0_o(is_jmpc0),
    .is_jmpc1_o(is_jmpc1)
  );

  // The fetched byte is current once the slot of the present pointer has been read.
  assign step_valid_o = locked & (st.fptr == st.qptr);
  assign exec_go = step_exec_i & step_valid_o;
  assign operand = is_copy ? st.hold : (st.adj + 16'h0000);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.adc_ld = 1'b0;
    next_st.fptr = st.qptr;
    if (avs_write_i && hit[H_CTRL] && avs_byteenable_i[0]) begin
      next_st.en = avs_writedata_i[CTRL_EN_BIT];
      next_st.run = avs_writedata_i[CTRL_RUN_BIT];
    end
    if (sw_write) begin
      if (hit[H_C1LIM]) begin
        next_st.c1lim = merge16(st.c1lim, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end
      if (hit[H_HOLD]) begin
        next_st.hold = merge16(st.hold, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end
      if (hit[H_ADJ]) begin
        next_st.adj = merge16(st.adj, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end
      if (hit[H_LIT]) begin
        next_st.lit = merge16(st.lit, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end
      if (hit[H_QPTR] && avs_byteenable_i[0]) begin
        next_st.qptr = avs_writedata_i[QPTR_W-1:0];
      end
    end
    if (!st.en) begin
      next_st.cnt1 = 16'h0000;
    end
    if (exec_go) begin
      next_st.qptr = st.qptr + 5'h01;
      if (is_ctrl && opt == OPT_LIT_TO_ADC) begin
        next_st.adc = st.lit;
        next_st.adc_ld = 1'b1;
      end else if (is_ctrl && opt == OPT_C1_TO_ADC) begin
        next_st.adc = st.cnt1;
        next_st.adc_ld = 1'b1;
      end
      if (is_addcopy && opt[2:0] == TGT_C1LIM) begin
        next_st.c1lim = is_copy ? st.hold : st.c1lim + st.adj;
      end
      if (is_addcopy && opt[2:0] == TGT_LIT) begin
        next_st.lit = is_copy ? st.hold : st.lit + st.adj;
      end
      if (is_jmp || (is_jmpc0 && !c0_at_limit_i)) begin
        next_st.qptr = target;
      end
      if (is_jmpc1 && st.cnt1 != st.c1lim) begin
        next_st.cnt1 = st.cnt1 + 16'h0001;
        next_st.qptr = target;
      end
    end
    unique case (st.rd)
      TSQ_RD_IDLE: begin
        if (avs_read_i) begin
          next_st.rd = TSQ_RD_FETCH;
        end
      end
      TSQ_RD_FETCH: begin
        next_st.rd = TSQ_RD_DONE;
        next_st.rdata = 32'h0000_0000;
        if (hit[H_C1LIM]) begin
          next_st.rdata[15:0] = st.c1lim;
        end
        if (hit[H_HOLD]) begin
          next_st.rdata[15:0] = st.hold;
        end
        if (hit[H_ADJ]) begin
          next_st.rdata[15:0] = st.adj;
        end
        if (hit[H_LIT]) begin
          next_st.rdata[15:0] = st.lit;
        end
        if (hit[H_QPTR]) begin
          next_st.rdata[QPTR_W-1:0] = st.qptr;
        end
        if (hit[H_CTRL]) begin
          next_st.rdata[CTRL_EN_BIT] = st.en;
          next_st.rdata[CTRL_RUN_BIT] = st.run;
        end
        if (hit[H_QUEUE]) begin
          next_st.rdata[15:0] = mem_word;
        end
      end
      TSQ_RD_DONE: begin
        next_st.rd = TSQ_RD_IDLE;
      end
      default: begin
        next_st.rd = TSQ_RD_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st.c1lim <= RST_C1LIM;
      st.hold <= RST_HOLD;
      st.adj <= RST_ADJ;
      st.lit <= RST_LIT;
      st.qptr <= RST_QPTR;
      st.fptr <= RST_QPTR;
      st.en <= 1'b0;
      st.run <= 1'b0;
      st.cnt1 <= 16'h0000;
      st.adc <= 16'h0000;
      st.adc_ld <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.rd <= TSQ_RD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = avs_read_i & (st.rd != TSQ_RD_DONE);
  assign step_byte_o = slot_byte;
  assign queue_pointer_o = st.qptr;
  assign counter_one_limit_o = st.c1lim;
  assign hold_operand_o = st.hold;
  assign adjust_operand_o = operand;
  assign literal_zero_value_o = st.lit;
  assign loop_counter_one_o = st.cnt1;
  assign adc_channel_select_o = st.adc;
  assign adc_select_load_o = st.adc_ld;
  assign sequencer_enable_o = st.en;
  assign sequencer_run_o = st.run;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_read_issue;
    avs_read_i && st.rd == TSQ_RD_IDLE;
  endsequence

  sequence s_read_answer;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence

  a_locked_no_write: assert property (
    locked && avs_write_i && !exec_go && (hit[H_C1LIM] || hit[H_HOLD] || hit[H_ADJ])
    |=> $stable(st.c1lim) && $stable(st.hold) && $stable(st.adj))
    else $error("register changed by a write while running");

  a_hold_write: assert property (
    !locked && avs_write_i && hit[H_HOLD] && avs_byteenable_i[1:0] == 2'b11
    |=> st.hold == $past(avs_writedata_i[15:0]))
    else $error("hold operand write not stored");

  a_limit_add: assert property (
    exec_go && is_addcopy && !is_copy && opt[2:0] == TGT_C1LIM
    |=> st.c1lim == 16'($past(st.c1lim) + $past(st.adj)))
    else $error("add step did not sum into the limit");

  a_literal_adc: assert property (
    exec_go && is_ctrl && opt == OPT_LIT_TO_ADC
    |=> adc_select_load_o && adc_channel_select_o == $past(st.lit))
    else $error("literal not sent to channel select");

  a_qptr_upper_zero: assert property (
    s_read_issue ##0 hit[H_QPTR]
    |-> ##1 avs_waitrequest_o ##1 (!avs_waitrequest_o && avs_readdata_o[31:QPTR_W] == 27'h0))
    else $error("queue pointer upper bits not zero");

  a_read_latency: assert property (
    s_read_issue |-> avs_waitrequest_o ##1 s_read_answer)
    else $error("read answer not after two cycles");

  a_jmpc1_limit: assert property (
    exec_go && is_jmpc1 && st.cnt1 == st.c1lim
    |=> st.qptr == 5'($past(st.qptr) + 5'h01) && $stable(st.cnt1))
    else $error("counter one jump did not advance at limit");

  a_jmpc1_loop: assert property (
    exec_go && is_jmpc1 && st.cnt1 != st.c1lim
    |=> st.cnt1 == 16'($past(st.cnt1) + 16'h0001) && st.qptr == $past(target))
    else $error("counter one jump did not loop");

  a_reset_clear: assert property (
    $rose(rst_b_i) |-> st.c1lim == RST_C1LIM && st.hold == RST_HOLD && st.qptr == RST_QPTR)
    else $error("registers not cleared by reset");

  a_step_nibbles: assert property (
    step_valid_o |-> cmd == step_byte_o[7:4] && opt == step_byte_o[3:0])
    else $error("step byte split wrongly");

endmodule

// *** testbench/tb.sv ***
module tb
  import tsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Table of plain register cases
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic [15:0] exp;
  } tsq_row_s;

  localparam int NROWS = 11;
  localparam tsq_row_s ROWS[NROWS] = '{
    '{OFS_C1LIM, 16'hA5C3, 2'h3, 16'hA5C3},
    '{OFS_HOLD, 16'h5A3C, 2'h3, 16'h5A3C},
    '{OFS_ADJ, 16'hF00F, 2'h3, 16'hF00F},
    '{OFS_LIT, 16'h0E81, 2'h3, 16'h0E81},
    '{OFS_QPTR, 16'hFFFF, 2'h3, 16'h001F},
    '{OFS_QPTR, 16'h0015, 2'h3, 16'h0015},
    '{6'h28, 16'h1234, 2'h3, 16'h1234},
    '{6'h28, 16'hABFF, 2'h2, 16'hAB34},
    '{6'h28, 16'h00CD, 2'h1, 16'hABCD},
    '{OFS_C1LIM, 16'h1111, 2'h1, 16'hA511},
    '{6'h18, 16'hFFFF, 2'h3, 16'h0000}
  };

  logic clk_sys_i;
  logic rst_b_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic step_exec_i;
  logic c0_at_limit_i;
  logic [7:0] step_byte_o;
  logic step_valid_o;
  logic [QPTR_W-1:0] queue_pointer_o;
  logic [15:0] counter_one_limit_o;
  logic [15:0] hold_operand_o;
  logic [15:0] adjust_operand_o;
  logic [15:0] literal_zero_value_o;
  logic [15:0] loop_counter_one_o;
  logic [15:0] adc_channel_select_o;
  logic adc_select_load_o;
  logic sequencer_enable_o;
  logic sequencer_run_o;
  int mismatches;
  int samples_checked;
  logic [31:0] rdata;

  tsq_queue_regs i_tsq_queue_regs (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .step_exec_i(step_exec_i),
    .c0_at_limit_i(c0_at_limit_i),
    .step_byte_o(step_byte_o),
    .step_valid_o(step_valid_o),
    .queue_pointer_o(queue_pointer_o),
    .counter_one_limit_o(counter_one_limit_o),
    .hold_operand_o(hold_operand_o),
    .adjust_operand_o(adjust_operand_o),
    .literal_zero_value_o(literal_zero_value_o),
    .loop_counter_one_o(loop_counter_one_o),
    .adc_channel_select_o(adc_channel_select_o),
    .adc_select_load_o(adc_select_load_o),
    .sequencer_enable_o(sequencer_enable_o),
    .sequencer_run_o(sequencer_run_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Each bus task is entered just after a rising edge and leaves one idle edge behind it.
  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= {2'b00, be};
    avs_write_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    chk(32'(n), 32'h1, "write answer latency");
    @(posedge clk_sys_i);
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    chk(32'(n), 32'h3, "read answer latency");
    @(posedge clk_sys_i);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string what);
    logic [31:0] q;
    bus_rd(a, q);
    chk(q, {16'h0000, exp}, what);
  endtask

  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask

  // Waits for a valid step, pulses exec once, then returns at the edge after it was taken.
  task automatic do_step();
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (step_valid_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(n < 20), 32'h1, "step valid");
    step_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    step_exec_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_b_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = '0;
    step_exec_i = 1'b0;
    c0_at_limit_i = 1'b0;
    do_reset();
    rd_chk(OFS_C1LIM, 16'h0000, "limit reset");
    rd_chk(OFS_HOLD, 16'h0000, "hold reset");
    rd_chk(OFS_ADJ, 16'h0000, "adjust reset");
    rd_chk(OFS_LIT, 16'h0000, "literal reset");
    rd_chk(OFS_QPTR, 16'h0000, "pointer reset");
    for (int i = 0; i < NROWS; i++) begin
      bus_wr(ROWS[i].addr, ROWS[i].wdata, ROWS[i].be);
      rd_chk(ROWS[i].addr, ROWS[i].exp, "table row");
    end
    chk(32'(queue_pointer_o), 32'h15, "pointer port");
    chk(32'(hold_operand_o), 32'h5A3C, "hold port");
    chk(32'(literal_zero_value_o), 32'h0E81, "literal port");
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk(32'(step_byte_o), 32'hAB, "odd slot in upper byte");
    chk(32'(adjust_operand_o), 32'hF00F, "adjust offered without copy");
    bus_wr(OFS_QPTR, 16'h0004, 2'h3);
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk(32'(step_byte_o), 32'hCD, "even slot in lower byte");
    // Program: jump-on-counter-one, copy hold to limit, literal to channel, jump to 0.
    bus_wr(OFS_QUEUE, 16'h19E2, 2'h3);
    bus_wr(OFS_QUEUE + 6'h04, 16'hA00E, 2'h3);
    bus_wr(OFS_C1LIM, 16'h0001, 2'h3);
    bus_wr(OFS_HOLD, 16'h0777, 2'h3);
    bus_wr(OFS_QPTR, 16'h0000, 2'h3);
    bus_wr(OFS_CTRL, 16'h0003, 2'h3);
    chk(32'({sequencer_enable_o, sequencer_run_o}), 32'h3, "control bits");
    do_step();
    chk(32'(queue_pointer_o), 32'h02, "loop jump target");
    chk(32'(loop_counter_one_o), 32'h0001, "counter one step");
    do_step();
    chk(32'(adc_select_load_o), 32'h1, "channel load pulse");
    chk(32'(adc_channel_select_o), 32'h0E81, "literal to channel");
    do_step();
    chk(32'(queue_pointer_o), 32'h00, "plain jump");
    do_step();
    chk(32'(queue_pointer_o), 32'h01, "limit reached advances");
    @(posedge clk_sys_i);
    chk(32'(adjust_operand_o), 32'h0777, "hold offered for copy");
    do_step();
    chk(32'(counter_one_limit_o), 32'h0777, "copy of hold");
    chk(32'(queue_pointer_o), 32'h02, "advance after copy");
    // Writes while enabled and running must be dropped.
    bus_wr(OFS_HOLD, 16'hDEAD, 2'h3);
    bus_wr(OFS_QPTR, 16'h0007, 2'h3);
    bus_wr(OFS_QUEUE, 16'hFFFF, 2'h3);
    rd_chk(OFS_HOLD, 16'h0777, "hold locked");
    chk(32'(queue_pointer_o), 32'h02, "pointer locked");
    rd_chk(OFS_QUEUE, 16'h19E2, "queue locked");
    bus_wr(OFS_CTRL, 16'h0001, 2'h3);
    bus_wr(OFS_HOLD, 16'hBEEF, 2'h3);
    rd_chk(OFS_HOLD, 16'hBEEF, "hold writable when stopped");
    // Add step, counter one to channel, and a counter-zero jump at its limit.
    bus_wr(OFS_QUEUE + 6'h0C, 16'h0D11, 2'h3);
    bus_wr(OFS_QUEUE + 6'h10, 16'h00C5, 2'h3);
    bus_wr(OFS_ADJ, 16'h0002, 2'h3);
    bus_wr(OFS_QPTR, 16'h0006, 2'h3);
    bus_wr(OFS_CTRL, 16'h0003, 2'h3);
    do_step();
    chk(32'(counter_one_limit_o), 32'h0779, "add of adjust");
    do_step();
    chk(32'(adc_channel_select_o), 32'h0001, "counter one to channel");
    c0_at_limit_i <= 1'b1;
    do_step();
    chk(32'(queue_pointer_o), 32'h09, "counter zero at limit advances");
    // Step words survive a reset while running, the rest clears.
    do_reset();
    rd_chk(OFS_QUEUE, 16'h19E2, "word 0 kept");
    rd_chk(OFS_QUEUE + 6'h04, 16'hA00E, "word 1 kept");
    rd_chk(OFS_QUEUE + 6'h08, 16'hABCD, "word 2 kept");
    rd_chk(OFS_QUEUE + 6'h0C, 16'h0D11, "word 3 kept");
    rd_chk(OFS_HOLD, 16'h0000, "hold cleared");
    rd_chk(OFS_C1LIM, 16'h0000, "limit cleared");
    rd_chk(OFS_ADJ, 16'h0000, "adjust cleared");
    chk(32'(queue_pointer_o), 32'h00, "pointer cleared");
    chk(32'({sequencer_enable_o, sequencer_run_o}), 32'h0, "control cleared");
    complete_run();
  end
endmodule
